// [pkg/scn_pkg.sv]
// Purpose: Shared constants for the system clock and NMI controller.
// Assumes: 125 MHz bus clock, APB register access, 32-bit words.
// Notes: Frequencies are in Hz, voltages in mV, times in ps.
package scn_pkg;
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned INTERNAL_OSC_HZ = 12000000;
   localparam int unsigned INTERNAL_OSC_PERIOD_PS = 83333;
   // One internal oscillator period, rounded up to whole bus clocks.
   localparam int unsigned INTERNAL_OSC_TICK_CYC =
      (INTERNAL_OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FAIL_INTERNAL_OSC_PERIODS = 32;
   localparam int unsigned INTERNAL_OSC_DIV4_HZ = 3000000;
   localparam int unsigned LFIOSC_HZ = 30000;
   localparam int unsigned ADC_HZ = 16000000;
   localparam int unsigned CRYSTAL_SELECT_MIN_HZ = 1000000;
   localparam int unsigned CRYSTAL_SELECT_MAX_HZ = 16384000;
   localparam int unsigned PLL_REF_MIN_HZ = 3579545;
   localparam int unsigned CRYSTAL_SELECT_CODES = 32;
   localparam int unsigned CRYSTAL_SELECT_STEP_HZ =
      (CRYSTAL_SELECT_MAX_HZ - CRYSTAL_SELECT_MIN_HZ) / (CRYSTAL_SELECT_CODES - 1);
   localparam int unsigned VTRIM_MIN_MV = 2250;
   localparam int unsigned VTRIM_MAX_MV = 2750;
   localparam int unsigned VOLTAGE_STEP_MV = 25;
   localparam logic [4:0] VTRIM_MAX_CODE =
      5'((VTRIM_MAX_MV - VTRIM_MIN_MV) / VOLTAGE_STEP_MV);
   localparam logic [4:0] VTRIM_RST = 5'h0A;

   typedef enum logic [2:0] {
      SRC_INTERNAL_OSC = 3'h0,
      SRC_MAIN_OSC = 3'h1,
      SRC_INTERNAL_OSC_DIV4 = 3'h2,
      SRC_LFIOSC = 3'h3,
      SRC_RTOSC = 3'h4,
      SRC_PLL = 3'h5
   } scn_src_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SWITCH = 2'h1,
      ST_HOLD = 2'h3,
      ST_BOOT = 2'h2
   } scn_fail_t;

   localparam logic [7:0] OFS_RUN_CFG = 8'h00;
   localparam logic [7:0] OFS_RUN_CFG_EXT = 8'h04;
   localparam logic [7:0] OFS_DSLP_CFG = 8'h08;
   localparam logic [7:0] OFS_MAIN_OSC_CTL = 8'h0C;
   localparam logic [7:0] OFS_RST_CAUSE = 8'h10;
   localparam logic [7:0] OFS_REG_CTL = 8'h14;
   localparam logic [7:0] OFS_PERIPH_GATE = 8'h18;
   localparam logic [7:0] OFS_PIN_LOCK = 8'h1C;
   localparam logic [7:0] OFS_PIN_COMMIT = 8'h20;
   localparam logic [7:0] OFS_PIN_ALTFN = 8'h24;
   localparam logic [7:0] OFS_PLL_CFG = 8'h28;
   localparam logic [7:0] OFS_INT_STAT = 8'h2C;
   localparam logic [7:0] OFS_INT_CLR = 8'h30;
   localparam logic [7:0] OFS_INT_EN = 8'h34;
   localparam logic [7:0] OFS_CLK_STAT = 8'h38;

   localparam int unsigned CFG_SRC_LSB = 0;
   localparam int unsigned CFG_CRYSTAL_SELECT_LSB = 3;
   localparam int unsigned CFG_PWRDN_BIT = 8;
   localparam int unsigned CFG_INTERNAL_OSC_DIS_BIT = 9;
   localparam int unsigned CFG_DIV_LSB = 10;
   localparam int unsigned EXT_SEL_BIT = 31;
   localparam logic [31:0] CFG_MASK = 32'h0000_3FFF;
   localparam logic [31:0] EXT_MASK = 32'h8000_3FFF;
   localparam logic [31:0] DSLP_MASK = 32'h0000_3C07;
   localparam logic [31:0] CFG_RST = 32'h0000_0178;
   localparam logic [31:0] EXT_RST = 32'h0000_0100;
   localparam logic [31:0] DSLP_RST = 32'h0000_0000;
   // Arbitrary unlock key for the NMI pin protection.
   localparam logic [31:0] PIN_UNLOCK_KEY = 32'h1ACC_E55D;
   localparam int unsigned INT_NMI_PIN = 0;
   localparam int unsigned INT_OSC_FAIL = 1;
   localparam int unsigned INT_BOOT_DONE = 2;
   localparam int unsigned INT_W = 3;
   localparam int unsigned RESET_CAUSE_REG_OSC_FAIL_BIT = 0;

   function automatic int unsigned crystal_select_hz(input logic [4:0] code);
      crystal_select_hz = CRYSTAL_SELECT_MIN_HZ + int'(code) * CRYSTAL_SELECT_STEP_HZ;
   endfunction : crystal_select_hz
endpackage : scn_pkg

// [sim/scn_far_model.sv]
// Purpose: Far side model of the NMI pin and the oscillator monitor.
// Assumes: The bench sends one-cycle command strobes.
// Notes: Both lines are always driven, so they idle at a known low.
`timescale 1ns/1ps
module scn_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_go,
   input wire logic err_go,
   output logic nmi_pin,
   output logic main_osc_freq_err
);
   logic [2:0] pin_r;
   logic [1:0] err_r;
   // The pin stays high for four edges so the synchronizer sees it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_r <= 3'h0;
         err_r <= 2'h0;
      end else begin
         pin_r <= pin_go ? 3'h4 : pin_r - 3'(pin_r != 3'h0);
         err_r <= err_go ? 2'h2 : err_r - 2'(err_r != 2'h0);
      end
   end
   assign nmi_pin = (pin_r != 3'h0);
   // A stable crystal reports no error until told to fail.
   assign main_osc_freq_err = (err_r != 2'h0);
endmodule : scn_far_model

// [sim/tb.sv]
// Purpose: Self-checking bench for the clock source and NMI controller.
// Assumes: APB master with one transfer at a time.
// Notes: Bus answers are taken at the rising edge, other outputs later.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
   bad_count++; $display("Error %0t got %0h exp %0h", $time, a, e); end end
module tb;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err_r;
   logic nmi_pin, deep_sleep, main_osc_freq_err, pin_go, err_go;
   logic pll_pwrdn, internal_osc_en, sys_reset_req, nmi_boot_vector, nmi_req, irq;
   logic [7:0] paddr, adc_div;
   logic [31:0] pwdata, prdata, rd, periph_clk_en;
   logic [2:0] sys_src_sel;
   logic [3:0] sys_div;
   logic [9:0] pll_mult;
   logic [4:0] trim;
   int bad_count, cmp_count, n, k;
   scn_clk_nmi_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmi_pin(nmi_pin), .deep_sleep(deep_sleep),
      .main_osc_freq_err(main_osc_freq_err), .sys_src_sel(sys_src_sel),
      .sys_div(sys_div), .pll_pwrdn(pll_pwrdn), .pll_mult(pll_mult),
      .internal_osc_en(internal_osc_en), .periph_clk_en(periph_clk_en), .adc_div(adc_div),
      .regulator_voltage_trim(trim), .sys_reset_req(sys_reset_req),
      .nmi_boot_vector(nmi_boot_vector), .nmi_req(nmi_req), .irq(irq));
   scn_far_model far (.clk(clk), .rst_n(rst_n), .pin_go(pin_go),
      .err_go(err_go), .nmi_pin(nmi_pin), .main_osc_freq_err(main_osc_freq_err));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task finish_test;
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Holds the request until pready is high at a rising edge, takes the
   // answer at that edge and only then releases the request.
   task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && t < 20) begin
         t++;
         @(posedge clk);
      end
      if (pready !== 1'b1) begin
         bad_count++;
         finish_test();
      end
      rd = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xf
   task rchk(input logic [7:0] a, input logic [31:0] e);
      xf(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rchk
   task settle;
      repeat (3) @(negedge clk);
   endtask : settle
   task strobe(input logic p);
      @(posedge clk);
      if (p) pin_go <= 1'b1;
      else err_go <= 1'b1;
      @(posedge clk);
      pin_go <= 1'b0;
      err_go <= 1'b0;
      repeat (8) @(negedge clk);
   endtask : strobe
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      deep_sleep = 1'b0;
      pin_go = 1'b0;
      err_go = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK({sys_src_sel, internal_osc_en, trim}, {3'h0, 1'b1, 5'h0A})
      rchk(scn_pkg::OFS_RUN_CFG, 32'h0000_0178);
      rchk(scn_pkg::OFS_RUN_CFG_EXT, 32'h0000_0100);
      xf(1'b0, 8'h3C, 32'h0);
      `CHK(err_r, 1'b1)
      xf(1'b1, scn_pkg::OFS_REG_CTL, 32'h14);
      settle();
      `CHK(trim, 5'h14)
      xf(1'b1, scn_pkg::OFS_REG_CTL, 32'h1F);
      rchk(scn_pkg::OFS_REG_CTL, 32'h14);
      for (int s = 0; s < 6; s++) begin
         xf(1'b1, scn_pkg::OFS_RUN_CFG, 32'h0000_00F8 | s);
         settle();
         `CHK(sys_src_sel, 3'(s))
      end
      `CHK(adc_div, 8'h0D)
      `CHK({pll_pwrdn, pll_mult}, {1'b0, 10'h019})
      rchk(scn_pkg::OFS_PLL_CFG, 32'h0000_0019);
      xf(1'b1, scn_pkg::OFS_RUN_CFG, 32'h0000_00FF);
      settle();
      `CHK({sys_src_sel, adc_div}, {3'h0, 8'h01})
      xf(1'b1, scn_pkg::OFS_RUN_CFG, 32'h0000_00FD);
      xf(1'b1, scn_pkg::OFS_RUN_CFG_EXT, 32'h8000_0103);
      settle();
      `CHK(sys_src_sel, 3'h3)
      xf(1'b1, scn_pkg::OFS_RUN_CFG_EXT, 32'h0000_0104);
      xf(1'b1, scn_pkg::OFS_DSLP_CFG, 32'h0000_1404);
      deep_sleep <= 1'b1;
      settle();
      `CHK({sys_src_sel, sys_div}, {3'h4, 4'h5})
      @(posedge clk);
      deep_sleep <= 1'b0;
      settle();
      `CHK({sys_src_sel, sys_div}, {3'h5, 4'h0})
      xf(1'b1, scn_pkg::OFS_PERIPH_GATE, 32'hA5A5_0F0F);
      settle();
      `CHK(periph_clk_en, 32'hA5A5_0F0F)
      xf(1'b1, scn_pkg::OFS_INT_EN, 32'h7);
      strobe(1'b1);
      xf(1'b1, scn_pkg::OFS_PIN_COMMIT, 32'h1);
      rchk(scn_pkg::OFS_PIN_COMMIT, 32'h0);
      rchk(scn_pkg::OFS_INT_STAT, 32'h0);
      xf(1'b1, scn_pkg::OFS_PIN_LOCK, scn_pkg::PIN_UNLOCK_KEY);
      xf(1'b1, scn_pkg::OFS_PIN_COMMIT, 32'h1);
      xf(1'b1, scn_pkg::OFS_PIN_ALTFN, 32'h1);
      rchk(scn_pkg::OFS_PIN_ALTFN, 32'h1);
      n = 0;
      @(posedge clk);
      pin_go <= 1'b1;
      @(posedge clk);
      pin_go <= 1'b0;
      repeat (10) begin
         @(negedge clk);
         if (nmi_req === 1'b1) n++;
      end
      `CHK(n, 1)
      `CHK(irq, 1'b1)
      rchk(scn_pkg::OFS_INT_STAT, 32'h1);
      xf(1'b1, scn_pkg::OFS_INT_CLR, 32'h1);
      xf(1'b1, scn_pkg::OFS_INT_EN, 32'h0);
      strobe(1'b1);
      `CHK(irq, 1'b0)
      xf(1'b1, scn_pkg::OFS_INT_CLR, 32'h1);
      xf(1'b1, scn_pkg::OFS_MAIN_OSC_CTL, 32'h0);
      strobe(1'b0);
      rchk(scn_pkg::OFS_RST_CAUSE, 32'h0);
      xf(1'b1, scn_pkg::OFS_RUN_CFG, 32'h0000_0379);
      settle();
      `CHK({sys_src_sel, internal_osc_en, pll_pwrdn}, {3'h1, 1'b0, 1'b1})
      xf(1'b1, scn_pkg::OFS_MAIN_OSC_CTL, 32'h1);
      @(posedge clk);
      err_go <= 1'b1;
      @(posedge clk);
      err_go <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK({sys_reset_req, sys_src_sel, internal_osc_en}, 5'h11)
      n = 0;
      k = 0;
      repeat (400) begin
         @(negedge clk);
         if (sys_reset_req === 1'b1) n++;
         if (nmi_boot_vector === 1'b1) k++;
      end
      `CHK(n >= 347 && n <= 353, 1'b1)
      `CHK(k, 1)
      rchk(scn_pkg::OFS_RST_CAUSE, 32'h1);
      rchk(scn_pkg::OFS_INT_STAT, 32'h6);
      rchk(scn_pkg::OFS_CLK_STAT, 32'h0000_0801);
      finish_test();
   end
endmodule : tb

// [verilog/scn_clk_nmi_ctrl.sv]
// Purpose: System clock source control and NMI sourcing, APB slave.
// Assumes: One 125 MHz clock; clocks themselves are muxed outside.
// Notes: Outputs are select codes and enables for the clock tree.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module scn_clk_nmi_ctrl #(
   parameter int unsigned NPERIPH = 32,
   parameter int unsigned PLL_VCO_HZ = 400000000,
   parameter int unsigned PLL_OUT_HZ = 200000000,
   parameter int unsigned RTOSC_HZ = 32768
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_pin,
   input wire logic deep_sleep,
   input wire logic main_osc_freq_err,
   output logic [2:0] sys_src_sel,
   output logic [3:0] sys_div,
   output logic pll_pwrdn,
   output logic [9:0] pll_mult,
   output logic internal_osc_en,
   output logic [NPERIPH-1:0] periph_clk_en,
   output logic [7:0] adc_div,
   output logic [4:0] regulator_voltage_trim,
   output logic sys_reset_req,
   output logic nmi_boot_vector,
   output logic nmi_req,
   output logic irq
);
   localparam int unsigned HW = $clog2(scn_pkg::FAIL_INTERNAL_OSC_PERIODS);
   localparam logic [HW-1:0] HOLD_LAST =
      HW'(scn_pkg::FAIL_INTERNAL_OSC_PERIODS - 1);
   localparam int unsigned HOLD_CYC =
      scn_pkg::FAIL_INTERNAL_OSC_PERIODS * scn_pkg::INTERNAL_OSC_TICK_CYC;

   logic [31:0] cfg_r, cfg_nxt, ext_r, ext_nxt, dslp_r, dslp_nxt;
   logic osc_chk_r, osc_chk_nxt, fail_flag_r, fail_flag_nxt;
   logic locked_r, locked_nxt, commit_r, commit_nxt;
   logic alt_en_r, alt_en_nxt;
   logic [4:0] trim_r, trim_nxt;
   logic [NPERIPH-1:0] gate_r, gate_nxt;
   logic [scn_pkg::INT_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
   logic nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_r, nmi_nxt;
   scn_pkg::scn_fail_t st_r, st_nxt;
   logic [HW-1:0] hold_r, hold_nxt;
   logic sys_rst_r, sys_rst_nxt, boot_r, boot_nxt;
   logic [2:0] src_r, src_nxt;
   logic [3:0] div_r, div_nxt;
   logic pwrdn_r, internal_osc_en_r, internal_osc_en_nxt;
   logic [9:0] mult_r, mult_nxt;
   logic [7:0] adc_r, adc_nxt;
   logic wr, setup, mapped, tick, tick_clr, fail_go;
   logic [4:0] crystal_select;
   logic [scn_pkg::INT_W-1:0] iset;
   logic [31:0] sel_cfg;
   int unsigned src_hz, xhz;

   // Answers come one cycle after setup, so pready is a plain flop.
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && pready_r;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= scn_pkg::OFS_CLK_STAT) && (a[1:0] == 2'h0);
   endfunction : is_mapped

   function automatic logic hit(input logic [7:0] ofs);
      hit = wr && (paddr == ofs);
   endfunction : hit

   scn_tick_div #(
      .DIV(scn_pkg::INTERNAL_OSC_TICK_CYC)
   ) u_internal_osc_tick (
      .clk(clk),
      .rst_n(rst_n),
      .clr(tick_clr),
      .tick(tick)
   );

   // Effective configuration and derived clock settings.
   always_comb begin
      crystal_select = cfg_r[scn_pkg::CFG_CRYSTAL_SELECT_LSB +: 5];
      xhz = scn_pkg::crystal_select_hz(crystal_select);
      sel_cfg = ext_r[scn_pkg::EXT_SEL_BIT] ? ext_r : cfg_r;
      if (deep_sleep) begin
         sel_cfg = dslp_r;
      end
      src_nxt = sel_cfg[scn_pkg::CFG_SRC_LSB +: 3];
      // Reserved codes fall back to the internal oscillator.
      if (src_nxt > scn_pkg::SRC_PLL || st_r != scn_pkg::ST_RUN) begin
         src_nxt = scn_pkg::SRC_INTERNAL_OSC;
      end
      div_nxt = sel_cfg[scn_pkg::CFG_DIV_LSB +: 4];
      case (src_nxt)
         scn_pkg::SRC_MAIN_OSC: src_hz = xhz;
         scn_pkg::SRC_INTERNAL_OSC_DIV4: src_hz = scn_pkg::INTERNAL_OSC_DIV4_HZ;
         scn_pkg::SRC_LFIOSC: src_hz = scn_pkg::LFIOSC_HZ;
         scn_pkg::SRC_RTOSC: src_hz = RTOSC_HZ;
         scn_pkg::SRC_PLL: src_hz = PLL_OUT_HZ;
         default: src_hz = scn_pkg::INTERNAL_OSC_HZ;
      endcase
      adc_nxt = 8'((src_hz + scn_pkg::ADC_HZ - 1) / scn_pkg::ADC_HZ);
      if (adc_nxt == 8'h00) begin
         adc_nxt = 8'h01;
      end
      mult_nxt = mult_r;
      if (!cfg_r[scn_pkg::CFG_PWRDN_BIT]) begin
         mult_nxt = 10'((PLL_VCO_HZ + xhz - 1) / xhz);
      end
   end

   // Oscillator failover sequence.
   always_comb begin
      st_nxt = st_r;
      hold_nxt = hold_r;
      sys_rst_nxt = sys_rst_r;
      boot_nxt = 1'b0;
      tick_clr = 1'b0;
      fail_go = 1'b0;
      case (st_r)
         scn_pkg::ST_RUN: begin
            if (osc_chk_r && main_osc_freq_err) begin
               fail_go = 1'b1;
               st_nxt = scn_pkg::ST_SWITCH;
            end
         end
         scn_pkg::ST_SWITCH: begin
            tick_clr = 1'b1;
            hold_nxt = '0;
            sys_rst_nxt = 1'b1;
            st_nxt = scn_pkg::ST_HOLD;
         end
         scn_pkg::ST_HOLD: begin
            if (tick) begin
               hold_nxt = hold_r + 1'b1;
               if (hold_r == HOLD_LAST) begin
                  sys_rst_nxt = 1'b0;
                  boot_nxt = 1'b1;
                  st_nxt = scn_pkg::ST_BOOT;
               end
            end
         end
         scn_pkg::ST_BOOT: st_nxt = scn_pkg::ST_RUN;
         default: st_nxt = scn_pkg::ST_RUN;
      endcase
      internal_osc_en_nxt = !cfg_r[scn_pkg::CFG_INTERNAL_OSC_DIS_BIT] ||
         (st_nxt != scn_pkg::ST_RUN);
   end

   // Register file, interrupt status and APB answer.
   always_comb begin
      cfg_nxt = cfg_r;
      ext_nxt = ext_r;
      dslp_nxt = dslp_r;
      osc_chk_nxt = osc_chk_r;
      fail_flag_nxt = fail_flag_r;
      locked_nxt = locked_r;
      commit_nxt = commit_r;
      alt_en_nxt = alt_en_r;
      trim_nxt = trim_r;
      gate_nxt = gate_r;
      ien_nxt = ien_r;
      ist_nxt = ist_r;
      if (hit(scn_pkg::OFS_RUN_CFG)) cfg_nxt = pwdata & scn_pkg::CFG_MASK;
      if (hit(scn_pkg::OFS_RUN_CFG_EXT)) ext_nxt = pwdata & scn_pkg::EXT_MASK;
      if (hit(scn_pkg::OFS_DSLP_CFG)) dslp_nxt = pwdata & scn_pkg::DSLP_MASK;
      if (hit(scn_pkg::OFS_MAIN_OSC_CTL)) osc_chk_nxt = pwdata[0];
      if (hit(scn_pkg::OFS_REG_CTL)) begin
         trim_nxt = pwdata[4:0];
         if (pwdata[4:0] > scn_pkg::VTRIM_MAX_CODE) begin
            trim_nxt = scn_pkg::VTRIM_MAX_CODE;
         end
      end
      if (hit(scn_pkg::OFS_PERIPH_GATE)) begin
         gate_nxt = pwdata[NPERIPH-1:0];
      end
      if (hit(scn_pkg::OFS_PIN_LOCK)) begin
         locked_nxt = (pwdata != scn_pkg::PIN_UNLOCK_KEY);
      end
      if (hit(scn_pkg::OFS_PIN_COMMIT) && !locked_r) begin
         commit_nxt = pwdata[0];
      end
      if (hit(scn_pkg::OFS_PIN_ALTFN) && commit_r) begin
         alt_en_nxt = pwdata[0];
      end
      if (hit(scn_pkg::OFS_INT_EN)) ien_nxt = pwdata[scn_pkg::INT_W-1:0];
      if (hit(scn_pkg::OFS_RST_CAUSE) &&
         pwdata[scn_pkg::RESET_CAUSE_REG_OSC_FAIL_BIT]) begin
         fail_flag_nxt = 1'b0;
      end
      if (hit(scn_pkg::OFS_INT_CLR)) begin
         ist_nxt = ist_r & ~pwdata[scn_pkg::INT_W-1:0];
      end
      // Hardware sets are applied after clears so an event is never lost.
      iset = '0;
      iset[scn_pkg::INT_NMI_PIN] = nmi_s2_r && !nmi_s3_r && alt_en_r;
      iset[scn_pkg::INT_OSC_FAIL] = fail_go;
      iset[scn_pkg::INT_BOOT_DONE] = boot_nxt;
      ist_nxt = ist_nxt | iset;
      if (fail_go) begin
         fail_flag_nxt = 1'b1;
         cfg_nxt[scn_pkg::CFG_SRC_LSB +: 3] = scn_pkg::SRC_INTERNAL_OSC;
         ext_nxt[scn_pkg::CFG_SRC_LSB +: 3] = scn_pkg::SRC_INTERNAL_OSC;
         cfg_nxt[scn_pkg::CFG_INTERNAL_OSC_DIS_BIT] = 1'b0;
      end
      irq_nxt = |(ist_nxt & ien_nxt);
      // A rising pin edge with the pin function enabled, or the failover boot, starts the NMI.
      nmi_nxt = iset[scn_pkg::INT_NMI_PIN] || boot_nxt;
      mapped = is_mapped(paddr);
      pslverr_nxt = setup && !mapped;
      prdata_nxt = 32'h0000_0000;
      if (setup && !pwrite) begin
         case (paddr)
            scn_pkg::OFS_RUN_CFG: prdata_nxt = cfg_r;
            scn_pkg::OFS_RUN_CFG_EXT: prdata_nxt = ext_r;
            scn_pkg::OFS_DSLP_CFG: prdata_nxt = dslp_r;
            scn_pkg::OFS_MAIN_OSC_CTL: prdata_nxt[0] = osc_chk_r;
            scn_pkg::OFS_RST_CAUSE:
               prdata_nxt[scn_pkg::RESET_CAUSE_REG_OSC_FAIL_BIT] = fail_flag_r;
            scn_pkg::OFS_REG_CTL: prdata_nxt[4:0] = trim_r;
            scn_pkg::OFS_PERIPH_GATE: prdata_nxt[NPERIPH-1:0] = gate_r;
            scn_pkg::OFS_PIN_LOCK: prdata_nxt[0] = locked_r;
            scn_pkg::OFS_PIN_COMMIT: prdata_nxt[0] = commit_r;
            scn_pkg::OFS_PIN_ALTFN: prdata_nxt[0] = alt_en_r;
            scn_pkg::OFS_PLL_CFG: prdata_nxt = {22'h0, mult_r};
            scn_pkg::OFS_INT_STAT: prdata_nxt[scn_pkg::INT_W-1:0] = ist_r;
            scn_pkg::OFS_INT_EN: prdata_nxt[scn_pkg::INT_W-1:0] = ien_r;
            scn_pkg::OFS_CLK_STAT: prdata_nxt = {20'h0,
               xhz >= scn_pkg::PLL_REF_MIN_HZ,
               sys_rst_r, st_r, adc_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_r <= scn_pkg::CFG_RST;
         ext_r <= scn_pkg::EXT_RST;
         dslp_r <= scn_pkg::DSLP_RST;
         osc_chk_r <= 1'b0;
         fail_flag_r <= 1'b0;
         locked_r <= 1'b1;
         commit_r <= 1'b0;
         alt_en_r <= 1'b0;
         trim_r <= scn_pkg::VTRIM_RST;
         gate_r <= '0;
         ist_r <= '0;
         ien_r <= '0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
         nmi_r <= 1'b0;
         st_r <= scn_pkg::ST_RUN;
         hold_r <= '0;
         sys_rst_r <= 1'b0;
         boot_r <= 1'b0;
         src_r <= scn_pkg::SRC_INTERNAL_OSC;
         div_r <= 4'h0;
         pwrdn_r <= 1'b1;
         internal_osc_en_r <= 1'b1;
         mult_r <= 10'h000;
         adc_r <= 8'h01;
      end else begin
         cfg_r <= cfg_nxt;
         ext_r <= ext_nxt;
         dslp_r <= dslp_nxt;
         osc_chk_r <= osc_chk_nxt;
         fail_flag_r <= fail_flag_nxt;
         locked_r <= locked_nxt;
         commit_r <= commit_nxt;
         alt_en_r <= alt_en_nxt;
         trim_r <= trim_nxt;
         gate_r <= gate_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= setup;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
         nmi_s1_r <= nmi_pin;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
         nmi_r <= nmi_nxt;
         st_r <= st_nxt;
         hold_r <= hold_nxt;
         sys_rst_r <= sys_rst_nxt;
         boot_r <= boot_nxt;
         src_r <= src_nxt;
         div_r <= div_nxt;
         pwrdn_r <= sel_cfg[scn_pkg::CFG_PWRDN_BIT];
         internal_osc_en_r <= internal_osc_en_nxt;
         mult_r <= mult_nxt;
         adc_r <= adc_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign sys_src_sel = src_r;
   assign sys_div = div_r;
   assign pll_pwrdn = pwrdn_r;
   assign pll_mult = mult_r;
   assign internal_osc_en = internal_osc_en_r;
   assign periph_clk_en = gate_r;
   assign adc_div = adc_r;
   assign regulator_voltage_trim = trim_r;
   assign sys_reset_req = sys_rst_r;
   assign nmi_boot_vector = boot_r;
   assign nmi_req = nmi_r;
   assign irq = irq_r;

   // Helper count of cycles spent in the failover reset.
   int unsigned rst_cyc;
   always_ff @(posedge clk) begin
      if (!rst_n || !sys_rst_r) begin
         rst_cyc <= 0;
      end else begin
         rst_cyc <= rst_cyc + 1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence fail_seen;
      st_r == scn_pkg::ST_RUN && osc_chk_r && main_osc_freq_err;
   endsequence
   sequence fail_entry;
      fail_flag_r && st_r == scn_pkg::ST_SWITCH ##1 sys_rst_r && internal_osc_en_r;
   endsequence

   pin_edge_a: assert property (
      $rose(nmi_s2_r) && alt_en_r |=> nmi_req)
      else $error("Pin edge did not raise the interrupt.");
   pin_gate_a: assert property (
      nmi_req |-> $past(alt_en_r) || boot_r)
      else $error("Interrupt raised with the pin function off.");
   pin_commit_a: assert property (
      $rose(alt_en_r) |-> $past(commit_r))
      else $error("Pin function enabled without commit.");
   commit_lock_a: assert property (
      $rose(commit_r) |-> !$past(locked_r))
      else $error("Pin commit accepted while locked.");
   sync_path_a: assert property (
      $rose(nmi_pin) && alt_en_r ##1 (nmi_pin && alt_en_r)[*2] |=> nmi_req)
      else $error("Synchronised pin edge lost.");
   fail_flow_a: assert property (
      fail_seen |=> fail_entry)
      else $error("Oscillator error did not start the failover.");
   chk_off_a: assert property (
      st_r == scn_pkg::ST_RUN && !osc_chk_r |=> st_r == scn_pkg::ST_RUN)
      else $error("Failover started with the check disabled.");
   hold_len_a: assert property (
      $fell(sys_rst_r) |-> $past(rst_cyc) >= HOLD_CYC - 1 &&
         src_r == scn_pkg::SRC_INTERNAL_OSC)
      else $error("Failover reset shorter than required.");
   boot_nmi_a: assert property (
      $fell(sys_rst_r) |-> boot_r && nmi_req ##1 !boot_r)
      else $error("Reset release did not vector to the NMI.");
   ext_cfg_a: assert property (
      ext_r[scn_pkg::EXT_SEL_BIT] && !deep_sleep && st_r == scn_pkg::ST_RUN
      && ext_r[2:0] <= scn_pkg::SRC_PLL |=> src_r == $past(ext_r[2:0]))
      else $error("Extended source not applied.");
   // The divider is registered, so it is held against last cycle's source.
   adc_rate_a: assert property (
      int'(adc_r) * scn_pkg::ADC_HZ >= $past(src_hz) &&
      (adc_r == 8'h01 ||
      (int'(adc_r) - 1) * scn_pkg::ADC_HZ < $past(src_hz)))
      else $error("Converter clock divider off its target.");
   trim_max_a: assert property (
      trim_r <= scn_pkg::VTRIM_MAX_CODE)
      else $error("Regulator trim beyond the top step.");
endmodule : scn_clk_nmi_ctrl

// [verilog/scn_tick_div.sv]
// Purpose: Enable pulse divider standing in for a slower clock.
// Assumes: Single clock, synchronous active-low reset.
// Notes: A clear restarts the count so the first pulse is DIV away.
`timescale 1ns/1ps
module scn_tick_div #(
   parameter int unsigned DIV = 11
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   output logic tick
);
   localparam int unsigned W = $clog2(DIV + 1);
   logic [W-1:0] cnt_r, cnt_nxt;
   logic tick_r, tick_nxt;

   always_comb begin
      cnt_nxt = cnt_r + 1'b1;
      tick_nxt = 1'b0;
      if (clr) begin
         cnt_nxt = '0;
      end else if (cnt_r == W'(DIV - 1)) begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule : scn_tick_div
